// File: common/dcd_consts.vh
// Constants for the DDR3 command pin decoder: command codes, address
// bit positions, burst lengths and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH

// =====================================================================
// Command codes as {RAS_N, CAS_N, WE_N} with chip select low.
`define DCD_CMD_ACT 3'h3
`define DCD_CMD_PRE 3'h2
`define DCD_CMD_RD 3'h5
`define DCD_CMD_WR 3'h4
`define DCD_CMD_MRS 3'h0

// =====================================================================
// Address bit positions with a special meaning.
`define DCD_A_AP 10
`define DCD_A_TDQS 11
`define DCD_A_BC 12
`define DCD_COL_MSB 9

// =====================================================================
// Mode register 1 bank code and burst lengths in beats.
`define DCD_BA_MR1 3'h1
`define DCD_BL_FULL 4'h8
`define DCD_BL_CHOP 4'h4

// =====================================================================
// Reset values and synchroniser width.
`define DCD_RST_TDQS 1'b0
`define DCD_RST_BANKS 8'h00
`define DCD_SYNC_W 34

`endif

// File: rtl/dcd_buf2.v
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock; outputs come from flops.
`timescale 1ns/100ps

module dcd_buf2 #(
   parameter W = 8
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] in_data,
   input wire in_valid,
   output reg in_ready,
   output wire [W-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);

   // =================================================================
   // Storage: entry 0 is always the head.
   reg [W-1:0] mem_q [0:1];
   reg [W-1:0] mem_d [0:1];
   reg [1:0] vld_q;
   reg [1:0] vld_d;
   wire push;
   wire pop;

   assign push = in_valid & in_ready;
   assign pop = vld_q[0] & out_ready;
   assign out_data = mem_q[0];
   assign out_valid = vld_q[0];

   // Pop first, then place the new word in the lowest free entry.
   always @* begin
      mem_d[0] = mem_q[0];
      mem_d[1] = mem_q[1];
      vld_d = vld_q;
      if (pop) begin
         mem_d[0] = mem_q[1];
         vld_d = {1'b0, vld_q[1]};
      end
      if (push) begin
         if (!vld_d[0]) begin
            mem_d[0] = in_data;
            vld_d[0] = 1'b1;
         end else begin
            mem_d[1] = in_data;
            vld_d[1] = 1'b1;
         end
      end
   end

   // Ready is registered so that it never depends combinationally on the drain side.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_q[0] <= {W{1'b0}};
         mem_q[1] <= {W{1'b0}};
         vld_q <= 2'h0;
         in_ready <= 1'b0;
      end else begin
         mem_q[0] <= mem_d[0];
         mem_q[1] <= mem_d[1];
         vld_q <= vld_d;
         in_ready <= ~vld_d[1];
      end
   end

endmodule // dcd_buf2

// File: rtl/dcd_top.v
// DDR3 command pin decoder: decodes chip select, row, column and write
// strobes at each rising memory clock, tracks open banks, collects
// masked write beats and drives read beats with their strobe.
// Assumes every memory pin is asynchronous to CLK and that the memory
// clock is slow enough to be oversampled (bench period 160 ns).
//
// What this block does
// [R1] On read or write, address bit 10 high closes the bank afterwards.
// [R2] On precharge, address bit 10 low closes one bank, high all.
// [R3] On read or write, address bit 12 low chops the burst to four.
// [R4] Commands are decoded only when chip select is sampled low.
// [R5] Row, column and write strobes are sampled together at clock rise.
// [R6] Select, row low, column high, write high opens the addressed bank.
// [R7] Select, row low, column high, write low precharges.
// [R8] Row high, column low starts access; write high reads, low writes.
// [R9] Write beats with the mask sampled high are discarded.
// [R10] With termination strobe on, the mask is ignored and pins terminate.
// [R11] The device drives the strobe pair with edges aligned to read data.
// [R12] The controller drives the strobe pair with margin during writes.
// [R13] Bank address bits pick the bank for a command.
// [R14] Row address on bits 0 to 15, column address on bits 0 to 9.
// [R15] Mode register 1 write with address bit 11 set enables strobe.
// [R16] Other selected codes raise a separate strobe and latch the fields; a mode register 1 write also loads termination from address bit 11.
`timescale 1ns/100ps
`include "dcd_consts.vh"

module dcd_top #(
   parameter DW = 8
) (
   input wire CLK,
   input wire RSTN,
   input wire CK,
   input wire CS_N,
   input wire RAS_N,
   input wire CAS_N,
   input wire WE_N,
   input wire [2:0] BA,
   input wire [15:0] A,
   input wire DM,
   input wire [7:0] DQ_IN,
   input wire DQS_IN,
   output reg [7:0] DQ_OUT,
   output reg DQ_OE,
   output reg DQS_OUT,
   output reg DQS_N_OUT,
   output reg DQS_OE,
   output reg TDQS_TERM,
   output reg ACT_STB,
   output reg PRE_STB,
   output reg RD_STB,
   output reg WR_STB,
   output reg OTHER_STB,
   output reg [2:0] CMD_BANK,
   output reg [15:0] CMD_ROW,
   output reg [9:0] CMD_COL,
   output reg CMD_AUTO_PRE,
   output reg CMD_PRE_ALL,
   output reg CMD_CHOP,
   output reg [7:0] OPEN_BANKS,
   output reg WR_DROP,
   output wire [7:0] WR_DATA,
   output wire WR_VALID,
   input wire WR_READY,
   input wire [7:0] RD_DATA,
   input wire RD_VALID,
   output reg RD_READY
);

   // =================================================================
   // Pin synchronisers: every pin passes two flops together, so the
   // pins stay aligned with each other relative to the sampled clock.
   reg [`DCD_SYNC_W-1:0] meta_q;
   reg [`DCD_SYNC_W-1:0] sync_q;
   reg ck_d_q;
   reg dqs_d_q;
   wire ck_s;
   wire cs_n_s;
   wire ras_n_s;
   wire cas_n_s;
   wire we_n_s;
   wire [2:0] ba_s;
   wire [15:0] a_s;
   wire dm_s;
   wire [7:0] dq_s;
   wire dqs_s;
   wire ck_rise;
   wire ck_edge;
   wire dqs_edge;

   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         meta_q <= {`DCD_SYNC_W{1'b0}};
         sync_q <= {`DCD_SYNC_W{1'b0}};
         ck_d_q <= 1'b0;
         dqs_d_q <= 1'b0;
      end else begin
         meta_q <= {CK, CS_N, RAS_N, CAS_N, WE_N, BA, A, DM, DQ_IN, DQS_IN};
         sync_q <= meta_q;
         ck_d_q <= ck_s;
         dqs_d_q <= dqs_s;
      end
   end

   assign {ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s, dm_s, dq_s,
      dqs_s} = sync_q;
   assign ck_rise = ck_s & ~ck_d_q; // see [R5]
   assign ck_edge = ck_s ^ ck_d_q;
   assign dqs_edge = dqs_s ^ dqs_d_q; // see [R12]

   // =================================================================
   // Command decode, bank tracking and burst control.
   localparam ST_IDLE = 2'h0;
   localparam ST_WR = 2'h1;
   localparam ST_RD = 2'h2;

   reg [1:0] st_q;
   reg [3:0] cnt_q;
   reg [3:0] len_q;
   reg ap_q;
   reg [2:0] bank_q;
   reg tdqs_q;
   wire sel;
   wire [2:0] code;
   wire [3:0] blen;
   wire beat_keep;
   wire wr_beat;
   wire rd_take;
   wire buf_ready;
   wire last;

   assign sel = ck_rise & ~cs_n_s; // see [R4]
   assign code = {ras_n_s, cas_n_s, we_n_s};
   assign blen = a_s[`DCD_A_BC] ? `DCD_BL_FULL : `DCD_BL_CHOP; // see [R3]
   assign wr_beat = (st_q == ST_WR) & dqs_edge;
   // The mask is only honoured while the pin is not lent to termination.
   assign beat_keep = wr_beat & (tdqs_q | ~dm_s); // see [R9] see [R10]
   assign rd_take = RD_READY & RD_VALID;
   assign last = (cnt_q == len_q - 4'h1);

   // Decoded strobes and fields; one cycle pulses per sampled command.
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ACT_STB <= 1'b0;
         PRE_STB <= 1'b0;
         RD_STB <= 1'b0;
         WR_STB <= 1'b0;
         OTHER_STB <= 1'b0;
         CMD_BANK <= 3'h0;
         CMD_ROW <= 16'h0000;
         CMD_COL <= 10'h000;
         CMD_AUTO_PRE <= 1'b0;
         CMD_PRE_ALL <= 1'b0;
         CMD_CHOP <= 1'b0;
         tdqs_q <= `DCD_RST_TDQS;
         TDQS_TERM <= `DCD_RST_TDQS;
      end else begin
         ACT_STB <= sel & (code == `DCD_CMD_ACT); // see [R6]
         PRE_STB <= sel & (code == `DCD_CMD_PRE); // see [R7]
         RD_STB <= sel & (code == `DCD_CMD_RD); // see [R8]
         WR_STB <= sel & (code == `DCD_CMD_WR); // see [R8]
         OTHER_STB <= sel & (code != `DCD_CMD_ACT) &
            (code != `DCD_CMD_PRE) & (code != `DCD_CMD_RD) &
            (code != `DCD_CMD_WR); // see [R16]
         if (sel) begin
            CMD_BANK <= ba_s; // see [R13]
            CMD_ROW <= a_s; // see [R14]
            CMD_COL <= a_s[`DCD_COL_MSB:0]; // see [R14]
            CMD_AUTO_PRE <= a_s[`DCD_A_AP] & ras_n_s & ~cas_n_s; // see [R1]
            CMD_PRE_ALL <= a_s[`DCD_A_AP] & (code == `DCD_CMD_PRE); // see [R2]
            CMD_CHOP <= ~a_s[`DCD_A_BC] & ras_n_s; // see [R3]
            if (code == `DCD_CMD_MRS && ba_s == `DCD_BA_MR1) begin
               tdqs_q <= a_s[`DCD_A_TDQS]; // see [R15]
               TDQS_TERM <= a_s[`DCD_A_TDQS]; // see [R10]
            end
         end
      end
   end

   // Open bank map. An auto precharge closes the bank when its burst
   // ends, which may coincide with a new command; an activate or precharge wins.
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         OPEN_BANKS <= `DCD_RST_BANKS;
      end else if (sel && code == `DCD_CMD_ACT) begin
         OPEN_BANKS[ba_s] <= 1'b1; // see [R6]
      end else if (sel && code == `DCD_CMD_PRE) begin
         if (a_s[`DCD_A_AP]) begin
            OPEN_BANKS <= 8'h00; // see [R2]
         end else begin
            OPEN_BANKS[ba_s] <= 1'b0; // see [R2]
         end
      end else if (ap_q && last && (wr_beat || (st_q == ST_RD && rd_take)))
      begin
         OPEN_BANKS[bank_q] <= 1'b0; // see [R1]
      end
   end

   // Burst sequencer. A new column command restarts the burst; this
   // block does not model the column latencies of a real memory.
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         len_q <= `DCD_BL_FULL;
         ap_q <= 1'b0;
         bank_q <= 3'h0;
      end else if (sel && (code == `DCD_CMD_RD || code == `DCD_CMD_WR))
      begin
         st_q <= (code == `DCD_CMD_RD) ? ST_RD : ST_WR; // see [R8]
         cnt_q <= 4'h0;
         len_q <= blen; // see [R3]
         ap_q <= a_s[`DCD_A_AP]; // see [R1]
         bank_q <= ba_s; // see [R13]
      end else begin
         case (st_q)
            ST_WR: begin
               if (wr_beat) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (last) begin
                     st_q <= ST_IDLE;
                  end
               end
            end
            ST_RD: begin
               if (rd_take) begin
                  cnt_q <= cnt_q + 4'h1;
                  if (last) begin
                     st_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // =================================================================
   // Write path: kept beats enter the two-entry buffer; a beat that
   // finds the buffer full cannot be held off on a memory bus, so it is
   // flagged rather than silently lost.
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         WR_DROP <= 1'b0;
      end else begin
         WR_DROP <= beat_keep & ~buf_ready;
      end
   end

   dcd_buf2 #(
      .W(DW)
   ) u_wbuf (
      .clk(CLK),
      .rst_n(RSTN),
      .in_data(dq_s),
      .in_valid(beat_keep),
      .in_ready(buf_ready),
      .out_data(WR_DATA),
      .out_valid(WR_VALID),
      .out_ready(WR_READY)
   );

   // =================================================================
   // Read path: one beat per memory clock edge; data and strobe change
   // in the same flop update so that their edges line up.
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RD_READY <= 1'b0;
         DQ_OUT <= 8'h00;
         DQ_OE <= 1'b0;
         DQS_OUT <= 1'b0;
         DQS_N_OUT <= 1'b1;
         DQS_OE <= 1'b0;
      end else begin
         RD_READY <= (st_q == ST_RD) & ck_edge & ~rd_take;
         DQS_OE <= (st_q == ST_RD); // see [R11]
         DQ_OE <= (st_q == ST_RD);
         if (st_q != ST_RD) begin
            DQS_OUT <= 1'b0;
            DQS_N_OUT <= 1'b1;
         end else if (rd_take) begin
            DQ_OUT <= RD_DATA;
            DQS_OUT <= ~DQS_OUT; // see [R11]
            DQS_N_OUT <= DQS_OUT; // see [R11]
         end
      end
   end

endmodule // dcd_top

// File: sim/dcd_top_sva.sv
// Checker for the command pin decoder, watching the top-level ports.
// Assumes CLK and RSTN as in the design; bound to dcd_top at the foot.
`timescale 1ns/100ps

module dcd_chk (
   input logic CLK,
   input logic RSTN,
   input logic ACT_STB,
   input logic PRE_STB,
   input logic RD_STB,
   input logic WR_STB,
   input logic OTHER_STB,
   input logic [2:0] CMD_BANK,
   input logic CMD_PRE_ALL,
   input logic [7:0] OPEN_BANKS,
   input logic DQS_OUT,
   input logic DQS_N_OUT,
   input logic DQS_OE,
   input logic DQ_OE,
   input logic [7:0] DQ_OUT,
   input logic RD_READY,
   input logic RD_VALID,
   input logic [7:0] RD_DATA,
   input logic WR_VALID,
   input logic [7:0] WR_DATA,
   input logic WR_READY
);
   // =================================================================
   // Properties
   // All checks share one clock and one reset.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   wire [4:0] stb = {ACT_STB, PRE_STB, RD_STB, WR_STB, OTHER_STB};

   AST_STB_ONE: assert property ($onehot0(stb))
      else $error("two command strobes at once");
   AST_STB_PULSE: assert property (|stb |=> stb == 5'h00)
      else $error("command strobe longer than one cycle");
   AST_ACT_OPEN: assert property (ACT_STB |->
      OPEN_BANKS[CMD_BANK]) else $error("activated bank not open");
   AST_PRE_ONE: assert property (PRE_STB && !CMD_PRE_ALL |->
      OPEN_BANKS == ($past(OPEN_BANKS) & ~(8'h01 << CMD_BANK)))
      else $error("single precharge closed the wrong banks");
   AST_PRE_ALL: assert property (PRE_STB && CMD_PRE_ALL |->
      OPEN_BANKS == 8'h00) else $error("precharge all left a bank open");
   AST_DQS_IDLE: assert property (!DQS_OE |->
      !DQS_OUT && DQS_N_OUT) else $error("strobe pair not parked");
   AST_DQS_PAIR: assert property (DQS_N_OUT == !DQS_OUT)
      else $error("strobe pair not complementary");
   AST_OE_PAIR: assert property (DQ_OE == DQS_OE)
      else $error("data and strobe enables differ");
   AST_RD_BEAT: assert property (RD_READY && RD_VALID |=>
      DQ_OUT == $past(RD_DATA) && DQS_OUT != $past(DQS_OUT))
      else $error("read beat not aligned to strobe edge");
   AST_WR_HOLD: assert property (WR_VALID && !WR_READY |=>
      WR_VALID && $stable(WR_DATA)) else $error("write word lost");
endmodule // dcd_chk

bind dcd_top dcd_chk i_chk (.CLK, .RSTN, .ACT_STB, .PRE_STB, .RD_STB,
   .WR_STB, .OTHER_STB, .CMD_BANK, .CMD_PRE_ALL, .OPEN_BANKS, .DQS_OUT,
   .DQS_N_OUT, .DQS_OE, .DQ_OE, .DQ_OUT, .RD_READY, .RD_VALID, .RD_DATA,
   .WR_VALID, .WR_DATA, .WR_READY);

// File: sim/dcd_ctl.sv
// Controller model: memory clock, command pins and write strobe.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps

module dcd_ctl (
   output logic ck,
   output logic cs_n,
   output logic [2:0] cmd,
   output logic [2:0] ba,
   output logic [15:0] a,
   output logic dm,
   output logic [7:0] dq,
   output logic dqs
);
   // =================================================================
   // Free-running memory clock, 160 ns period; pins start deselected.
   initial begin
      ck = 1'b0;
      {cs_n, cmd, ba, a} = {1'b1, 3'h7, 3'h0, 16'h0000};
      {dm, dq, dqs} = 10'h000;
      forever #80 ck = ~ck;
   end

   // Pins change on the falling edge, half a period from the sampling
   // rise; then chip select goes high and the rest show the inverse, not a stale value.
   task automatic issue(input logic c, input logic [2:0] k, b,
         input logic [15:0] ad);
      @(negedge ck);
      {cs_n, cmd, ba, a} = {c, k, b, ad};
      @(negedge ck);
      {cs_n, cmd, ba, a} = {1'b1, ~k, ~b, ~ad};
   endtask

   // Data and mask stand 40 ns either side of each strobe edge.
   task automatic beats(input logic [63:0] d, input logic [7:0] m);
      for (int i = 0; i < 8; i++) begin
         dq = d[8*i +: 8];
         dm = m[i];
         #40 dqs = ~dqs;
         #40;
      end
      dq = ~dq;
      dm = ~dm;
   endtask
endmodule // dcd_ctl

// File: sim/tb.sv
// Self-checking bench for the command pin decoder.
// Assumes dcd_top, dcd_ctl and the bound checker are compiled.
`timescale 1ns/100ps

module tb;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic WR_READY = 1'b0;
   logic RD_VALID = 1'b0;
   logic [7:0] RD_DATA = 8'h00;
   wire CK, CS_N, RAS_N, CAS_N, WE_N, DM, DQS_IN;
   wire [2:0] BA, CMD_BANK;
   wire [15:0] A, CMD_ROW;
   wire [9:0] CMD_COL;
   wire [7:0] DQ_IN, DQ_OUT, WR_DATA, OPEN_BANKS;
   wire DQ_OE, DQS_OUT, DQS_N_OUT, DQS_OE, TDQS_TERM, ACT_STB, PRE_STB;
   wire RD_STB, WR_STB, OTHER_STB, CMD_AUTO_PRE, CMD_PRE_ALL, CMD_CHOP;
   wire WR_DROP, WR_VALID, RD_READY;
   int bad_count = 0, n_checks = 0, n_rd = 0, n_drop = 0;
   logic [31:0] seed = 32'h91da86ae;
   logic [7:0] wq[$], eq[$];
   logic [4:0] got;
   logic [15:0] r;
   logic stall = 1'b0, term = 1'b0;
   logic [2:0] oth[4] = '{3'h0, 3'h1, 3'h6, 3'h7};

   dcd_top i_dut (.CLK, .RSTN, .CK, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA, .A,
      .DM, .DQ_IN, .DQS_IN, .DQ_OUT, .DQ_OE, .DQS_OUT, .DQS_N_OUT, .DQS_OE,
      .TDQS_TERM, .ACT_STB, .PRE_STB, .RD_STB, .WR_STB, .OTHER_STB,
      .CMD_BANK, .CMD_ROW, .CMD_COL, .CMD_AUTO_PRE, .CMD_PRE_ALL, .CMD_CHOP,
      .OPEN_BANKS, .WR_DROP, .WR_DATA, .WR_VALID, .WR_READY, .RD_DATA,
      .RD_VALID, .RD_READY);
   dcd_ctl i_ctl (.ck(CK), .cs_n(CS_N), .cmd({RAS_N, CAS_N, WE_N}), .ba(BA),
      .a(A), .dm(DM), .dq(DQ_IN), .dqs(DQS_IN));

   // =================================================================
   // Clock, random sources and output monitor
   initial forever #5 CLK = ~CLK;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // A stall holds the sink still so that the two-entry buffer fills.
   always @(posedge CLK) begin
      WR_READY <= !stall && rnd() > 32'h55555555;
      RD_VALID <= rnd() > 32'h40000000;
      RD_DATA <= 8'(rnd());
      if (WR_VALID && WR_READY)
         wq.push_back(WR_DATA);
      n_rd += int'(RD_READY && RD_VALID);
      n_drop += int'(WR_DROP);
      if (|{ACT_STB, PRE_STB, RD_STB, WR_STB, OTHER_STB})
         got <= {ACT_STB, PRE_STB, RD_STB, WR_STB, OTHER_STB};
   end

   // =================================================================
   // Shared tasks
   task automatic chk(input logic [31:0] g, e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic cmd(input logic c, input logic [2:0] k, b,
         input logic [15:0] ad, input logic [4:0] e);
      got = 5'h00;
      i_ctl.issue(c, k, b, ad);
      chk(got, e);
   endtask

   task automatic rd(input logic [2:0] b, input logic [15:0] ad, int n);
      n_rd = 0;
      cmd(1'b0, 3'h5, b, ad, 5'h04);
      repeat (200) @(posedge CLK);
      chk(n_rd, n);
      chk({CMD_COL, CMD_CHOP, CMD_AUTO_PRE},
         {ad[9:0], !ad[12], ad[10]});
   endtask

   // Eight strobe edges are sent always; a chopped burst keeps four.
   task automatic wr(input logic [2:0] b, input logic [15:0] ad, int n,
         input logic [7:0] m);
      logic [63:0] d;
      d = {rnd(), rnd()};
      eq.delete();
      wq.delete();
      n_drop = 0;
      for (int i = 0; i < n; i++)
         if (!m[i] || term)
            eq.push_back(d[8*i +: 8]);
      if (stall)
         eq = eq[0:1];
      cmd(1'b0, 3'h4, b, ad, 5'h02);
      i_ctl.beats(d, m);
      repeat (30) @(posedge CLK);
      stall = 1'b0;
      repeat (30) @(posedge CLK);
      chk(wq.size(), eq.size());
      foreach (eq[i])
         chk(wq[i], eq[i]);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // =================================================================
   // Scenarios; the watchdog allows about thirteen times the expected run.
   initial begin
      #200us;
      bad_count++;
      give_verdict();
   end

   initial begin
      repeat (2) @(posedge CLK);
      RSTN <= 1'b1;
      @(posedge CLK);
      chk({OPEN_BANKS, TDQS_TERM, DQS_N_OUT, DQS_OE}, 11'h002);
      for (int b = 0; b < 8; b++) begin
         r = 16'(rnd());
         cmd(1'b0, 3'h3, 3'(b), r, 5'h10);
         chk({CMD_BANK, CMD_ROW, OPEN_BANKS},
            {3'(b), r, 8'hff >> (7 - b)});
      end
      cmd(1'b1, 3'h2, 3'h0, 16'h0400, 5'h00);
      cmd(1'b0, 3'h2, 3'h5, 16'h0000, 5'h08);
      chk({OPEN_BANKS, CMD_PRE_ALL}, 9'h1be);
      foreach (oth[i])
         cmd(1'b0, oth[i], 3'h2, 16'h0800, 5'h01);
      chk({OPEN_BANKS, TDQS_TERM}, 9'h1be);
      rd(3'h3, 16'h16a5, 8);
      chk(OPEN_BANKS, 8'hd7);
      rd(3'h4, 16'h0155, 4);
      chk(OPEN_BANKS, 8'hd7);
      wr(3'h0, 16'h1000, 8, 8'(rnd()));
      wr(3'h1, 16'h0403, 4, 8'h05);
      chk(OPEN_BANKS, 8'hd5);
      cmd(1'b0, 3'h0, 3'h1, 16'h0800, 5'h01);
      chk(TDQS_TERM, 1'b1);
      term = 1'b1;
      wr(3'h2, 16'h1000, 8, 8'hff);
      stall = 1'b1;
      wr(3'h6, 16'h1000, 8, 8'hff);
      chk(n_drop, 6);
      // Precharge of every bank with address bit 10 high.
      cmd(1'b0, 3'h2, 3'h0, 16'h0400, 5'h08);
      chk({OPEN_BANKS, CMD_PRE_ALL}, 9'h001);
      give_verdict();
   end
endmodule // tb
